// ==== bench/rbbd_prog_mem.sv ====
// Program and page-zero memory model feeding the decoder.
`timescale 1ns/1ps
module rbbd_prog_mem
    import rbbd_pkg::*;
(
    input wire logic [RBBD_AW-1:0] instr_addr,
    output logic [7:0] opcode,
    output logic [7:0] operand1,
    output logic [7:0] operand2,
    output logic [7:0] mem_data
);
    // Byte store; unwritten bytes hold a filler opcode, never unknowns.
    logic [7:0] mem [0:65535];

    // Loads one byte; the bench calls it only while the decoder is idle.
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask : put

    // The filler is an opcode outside this block, so strays decode as none.
    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'h9D;
        end
    end

    // Operand bytes follow the opcode in address order.
    assign opcode = mem[instr_addr];
    assign operand1 = mem[instr_addr + 16'h0001];
    assign operand2 = mem[instr_addr + 16'h0002];
    // Bit operations reach page zero only, so the upper byte is zero.
    assign mem_data = mem[{8'h00, operand1}];
endmodule : rbbd_prog_mem

// ==== bench/test_rbbd_decoder.sv ====
// Self-checking bench for the instruction group decoder.
`timescale 1ns/1ps
module test_rbbd_decoder;
    import rbbd_pkg::*;
    logic mclk, resetn, op_valid, irq_pin, dec_valid_q, busy_q;
    logic [7:0] opcode, operand1, operand2, mem_data;
    logic [15:0] instr_addr, next_pc_q, bit_addr_q;
    rbbd_flg_s flags;
    rbbd_dec_s dec_q;
    int miscompares, check_count;

    // Free-running 40 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    rbbd_prog_mem i_mem (.instr_addr(instr_addr), .opcode(opcode),
        .operand1(operand1), .operand2(operand2), .mem_data(mem_data));

    rbbd_decoder i_dut (.mclk(mclk), .resetn(resetn), .op_valid(op_valid),
        .opcode(opcode), .operand1(operand1), .operand2(operand2),
        .instr_addr(instr_addr), .mem_data(mem_data), .flags(flags),
        .irq_pin(irq_pin), .dec_valid_q(dec_valid_q), .dec_q(dec_q),
        .next_pc_q(next_pc_q), .bit_addr_q(bit_addr_q), .busy_q(busy_q));

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // One comparison; four-state equality so unknowns never match.
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Issues one request at address a and times busy against cyc.
    // With hold set, a second request stays up through busy to be refused.
    task automatic exec(input logic [15:0] a, input bit hold,
                        input logic [3:0] cyc);
        int n;
        // One idle edge first, so op_valid is never written twice at once.
        @(negedge mclk);
        instr_addr = a;
        op_valid = 1'b1;
        @(negedge mclk);
        check("dec_valid_q", 16'h0001, {15'h0000, dec_valid_q});
        if (hold) begin
            instr_addr = 16'h0200;
        end else begin
            op_valid = 1'b0;
        end
        n = 0;
        // Bounded wait; a stuck busy ends the run as a failure.
        while (busy_q === 1'b1 && n < 20) begin
            n++;
            @(negedge mclk);
            check("dec_valid_q", 16'h0000, {15'h0000, dec_valid_q});
        end
        op_valid = 1'b0;
        check("busy cycles", {12'h000, cyc}, n[15:0]);
        if (n >= 20) begin
            miscompares++;
            end_sim();
        end
    endtask : exec

    // Compares the class, length, count and write-back fields.
    task automatic chk_dec(input logic [7:0] c, input logic [1:0] l,
                           input logic [3:0] y, input logic w);
        check("cls", {8'h00, c}, {8'h00, dec_q.cls});
        check("len", {14'h0000, l}, {14'h0000, dec_q.len});
        check("cyc", {12'h000, y}, {12'h000, dec_q.cyc});
        check("wb", {15'h0000, w}, {15'h0000, dec_q.wb});
    endtask : chk_dec

    // Every rotate and test opcode in all five addressing forms.
    task automatic t_rmw();
        logic [3:0] md [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
        logic [3:0] ol [3] = '{RBBD_OPL_ROR, RBBD_OPL_ROL, RBBD_OPL_TST};
        logic [3:0] y;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 5; j++) begin
                y = (md[j] == 4'h6) ? 4'h7 : (md[j] < 4'h6 && md[j] > 4'h3)
                    ? 4'h4 : 4'h6;
                i_mem.put(16'h0100, {md[j], ol[i]});
                exec(16'h0100, 1'b0, y);
                chk_dec(8'h02 << i, (md[j] == 4'h3 || md[j] == 4'h6) ?
                    2'h2 : 2'h1, y, i != 2);
                check("mode", {12'h000, md[j]}, {12'h000, dec_q.mode});
            end
        end
        $display("test rmw done");
    endtask : t_rmw

    // Branch condition worked out from the flags and the pin level.
    function automatic logic br_exp(logic [7:0] o, rbbd_flg_s f, logic q);
        case (o)
            8'h22: return !(f.c | f.z);
            8'h23: return f.c | f.z;
            8'h24: return !f.c;
            8'h25: return f.c;
            8'h28: return !f.h;
            8'h29: return f.h;
            8'h2C: return !f.i;
            8'h2D: return f.i;
            8'h2E: return !q;
            default: return q;
        endcase
    endfunction : br_exp

    // Each branch under three flag sets, with a backward displacement.
    task automatic t_branch();
        logic [7:0] op [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h29,
            8'h2C, 8'h2D, 8'h2E, 8'h2F};
        logic [4:0] fs [3] = '{5'h00, 5'h1F, 5'h02};
        logic tk;
        for (int s = 0; s < 3; s++) begin
            flags = rbbd_flg_s'(fs[s]);
            irq_pin = (s == 1);
            // The pin passes a synchroniser, so let it settle first.
            repeat (6) @(negedge mclk);
            for (int i = 0; i < 10; i++) begin
                tk = br_exp(op[i], flags, irq_pin);
                i_mem.put(16'h0100, op[i]);
                i_mem.put(16'h0101, 8'hF0);
                exec(16'h0100, 1'b0, 4'h4);
                chk_dec(8'h10, 2'h2, 4'h4, 1'b0);
                check("taken", {15'h0000, tk}, {15'h0000, dec_q.taken});
                check("next_pc", tk ? 16'h00F2 : 16'h0102, next_pc_q);
            end
        end
        $display("test branch done");
    endtask : t_branch

    // Test-and-branch, set and clear for every bit number.
    task automatic t_bit();
        logic [7:0] o;
        logic tk;
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 4; k++) begin
                o = {3'h0, k[1], n[2:0], k[0]};
                tk = k[1] ? 1'b0 : (8'hA5 >> n) & 1'b1 ^ k[0];
                i_mem.put(16'h0100, o);
                i_mem.put(16'h0101, 8'h80 + n[7:0]);
                i_mem.put(16'h0102, 8'h10);
                i_mem.put(16'h0080 + n[15:0], 8'hA5);
                exec(16'h0100, 1'b0, k[1] ? 4'h7 : 4'hA);
                if (k[1]) begin
                    chk_dec(8'h40 << k[0], 2'h2, 4'h7, 1'b1);
                end else begin
                    chk_dec(8'h20, 2'h3, 4'hA, 1'b0);
                    check("taken", {15'h0000, tk},
                        {15'h0000, dec_q.taken});
                    check("next_pc", tk ? 16'h0113 : 16'h0103,
                        next_pc_q);
                end
                check("bitn", n[15:0], {13'h0000, dec_q.bitn});
                check("bit_addr", 16'h0080 + n[15:0], bit_addr_q);
            end
        end
        $display("test bit done");
    endtask : t_bit

    // A request held through busy is ignored; then an unknown opcode.
    task automatic t_refuse();
        i_mem.put(16'h0100, 8'h3D);
        exec(16'h0100, 1'b1, 4'h6);
        chk_dec(8'h08, 2'h2, 4'h6, 1'b0);
        exec(16'h0200, 1'b0, 4'h1);
        chk_dec(8'h01, 2'h1, 4'h1, 1'b0);
        check("known", 16'h0000, {15'h0000, dec_q.known});
        check("next_pc", 16'h0201, next_pc_q);
        $display("test refuse done");
    endtask : t_refuse

    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial begin
        resetn = 1'b0;
        op_valid = 1'b0;
        instr_addr = 16'h0000;
        flags = '0;
        irq_pin = 1'b0;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        check("busy_q", 16'h0000, {15'h0000, busy_q});
        check("next_pc", 16'h0000, next_pc_q);
        t_rmw();
        t_branch();
        t_bit();
        t_refuse();
        end_sim();
    end
endmodule : test_rbbd_decoder

// ==== rtl/rbbd_decoder.sv ====
// Decoder and cycle timer for rotate, test, branch and bit instructions.
`timescale 1ns/1ps
// Functional notes
// - Rotate right: 46/56/36/76/66, timed per form.
// - Rotate left: 49/59/39/79/69, timed per form.
// - Test opcodes 3D..7D share read/modify/write timing.
// - Test updates flags, never writes back.
// - 22 higher, 23 lower-or-same, 2 bytes 4.
// - 24 carry clear, 25 carry set.
// - 28/29 branch on half-carry clear/set.
// - 2C/2D branch on interrupt mask clear/set.
// - Sample interrupt pin; 2E branches when low.
// - 2F branches when interrupt line high.
// - Bit-set test branch: 3 bytes, 10 cycles.
// - Bit-clear test branch 01+2n: 3 bytes, 10.
// - Set 10+2n, clear 11+2n: 2 bytes, 7.
// - Bit operations address only the first 256 bytes.
module rbbd_decoder
    import rbbd_pkg::*;
#(
    parameter int AW = RBBD_AW
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [AW-1:0] instr_addr,
    input wire logic [7:0] mem_data,
    input wire rbbd_flg_s flags,
    input wire logic irq_pin,
    output logic dec_valid_q,
    output rbbd_dec_s dec_q,
    output logic [AW-1:0] next_pc_q,
    output logic [AW-1:0] bit_addr_q,
    output logic busy_q
);
    // Interrupt pin synchroniser stages and the filtered level.
    logic irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
    logic irq_lvl_d;
    // Sequencer state and remaining cycle count.
    rbbd_st_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic dec_valid_d, busy_d;
    rbbd_dec_s dec_d, dec_now;
    logic [AW-1:0] next_pc_d, bit_addr_d, seq_pc;
    logic take;

    // Timing of a read/modify/write form, picked by the high nibble.
    function automatic logic [5:0] rmw_time(input logic [3:0] mode);
        case (mode)
            RBBD_MODE_ACC: rmw_time = {RBBD_LEN1, RBBD_CYC_REG};
            RBBD_MODE_IDX: rmw_time = {RBBD_LEN1, RBBD_CYC_REG};
            RBBD_MODE_DIR: rmw_time = {RBBD_LEN2, RBBD_CYC_MEM};
            RBBD_MODE_IX0: rmw_time = {RBBD_LEN1, RBBD_CYC_MEM};
            RBBD_MODE_IX1: rmw_time = {RBBD_LEN2, RBBD_CYC_IX1};
            default: rmw_time = {RBBD_LEN1, RBBD_CYC_UNK};
        endcase
    endfunction : rmw_time

    // True when the form nibble is one of the five handled forms.
    function automatic logic rmw_mode_ok(input logic [3:0] mode);
        rmw_mode_ok = (mode == RBBD_MODE_ACC) || (mode == RBBD_MODE_IDX) ||
            (mode == RBBD_MODE_DIR) || (mode == RBBD_MODE_IX0) ||
            (mode == RBBD_MODE_IX1);
    endfunction : rmw_mode_ok

    // Branch condition for the relative branch opcodes.
    function automatic logic br_cond(input logic [7:0] op,
                                     input rbbd_flg_s f,
                                     input logic irq);
        case (op)
            RBBD_OP_BHI: br_cond = !(f.c | f.z);
            RBBD_OP_BLS: br_cond = f.c | f.z;
            RBBD_OP_BCC: br_cond = !f.c;
            RBBD_OP_BCS: br_cond = f.c;
            RBBD_OP_BRANCH_IF_HALF_CARRY_CLEAR: br_cond = !f.h;
            RBBD_OP_BRANCH_IF_HALF_CARRY_SET: br_cond = f.h;
            RBBD_OP_BMC: br_cond = !f.i;
            RBBD_OP_BMS: br_cond = f.i;
            RBBD_OP_BIL: br_cond = !irq;
            RBBD_OP_BIH: br_cond = irq;
            default: br_cond = 1'b0;
        endcase
    endfunction : br_cond

    // True for the relative branch opcodes that this block owns.
    function automatic logic is_branch(input logic [7:0] op);
        case (op)
            RBBD_OP_BHI, RBBD_OP_BLS, RBBD_OP_BCC, RBBD_OP_BCS,
            RBBD_OP_BRANCH_IF_HALF_CARRY_CLEAR, RBBD_OP_BRANCH_IF_HALF_CARRY_SET, RBBD_OP_BMC, RBBD_OP_BMS,
            RBBD_OP_BIL, RBBD_OP_BIH: is_branch = 1'b1;
            default: is_branch = 1'b0;
        endcase
    endfunction : is_branch

    // Combinational decode of the presented opcode.
    always_comb begin
        dec_now = '0;
        dec_now.cls = RBBD_CLS_NONE;
        dec_now.mode = opcode[7:4];
        dec_now.len = RBBD_LEN1;
        dec_now.cyc = RBBD_CYC_UNK;
        dec_now.bitn = opcode[3:1];
        if (rmw_mode_ok(opcode[7:4]) && (opcode[3:0] == RBBD_OPL_ROR)) begin
            dec_now.cls = RBBD_CLS_ROR;
            dec_now.known = 1'b1;
            {dec_now.len, dec_now.cyc} = rmw_time(opcode[7:4]);
            dec_now.wb = 1'b1;
        end else if (rmw_mode_ok(opcode[7:4]) &&
                     (opcode[3:0] == RBBD_OPL_ROL)) begin
            dec_now.cls = RBBD_CLS_ROL;
            dec_now.known = 1'b1;
            {dec_now.len, dec_now.cyc} = rmw_time(opcode[7:4]);
            dec_now.wb = 1'b1;
        end else if (rmw_mode_ok(opcode[7:4]) &&
                     (opcode[3:0] == RBBD_OPL_TST)) begin
            dec_now.cls = RBBD_CLS_TST;
            dec_now.known = 1'b1;
            {dec_now.len, dec_now.cyc} = rmw_time(opcode[7:4]);
            dec_now.wb = 1'b0;
        end else if (is_branch(opcode)) begin
            // Relative branch: two bytes, fixed time, taken or not.
            dec_now.cls = RBBD_CLS_BRANCH;
            dec_now.known = 1'b1;
            dec_now.len = RBBD_LEN2;
            dec_now.cyc = RBBD_CYC_BR;
            dec_now.taken = br_cond(opcode, flags, irq_lvl_q);
        end else if (opcode[7:4] == RBBD_HI_BTB) begin
            // Test bit and branch: three bytes, ten cycles.
            dec_now.cls = RBBD_CLS_BTB;
            dec_now.known = 1'b1;
            dec_now.len = RBBD_LEN3;
            dec_now.cyc = RBBD_CYC_BTB;
            // Odd opcode branches on a clear bit.
            dec_now.taken = mem_data[opcode[3:1]] ^ opcode[0];
        end else if (opcode[7:4] == RBBD_HI_BSC) begin
            // Set on even opcode, clear on odd one.
            dec_now.cls = opcode[0] ? RBBD_CLS_CLEAR_MEMORY_BIT : RBBD_CLS_SET_MEMORY_BIT;
            dec_now.known = 1'b1;
            dec_now.len = RBBD_LEN2;
            dec_now.cyc = RBBD_CYC_BSC;
            dec_now.wb = 1'b1;
        end
    end

    // Sequential address and branch target arithmetic.
    always_comb begin
        seq_pc = instr_addr + AW'(dec_now.len);
        // Bit operations reach page zero only.
        bit_addr_d = {{(AW-8){1'b0}}, operand1};
        if (dec_now.taken && (dec_now.cls == RBBD_CLS_BTB)) begin
            next_pc_d = seq_pc + {{(AW-8){operand2[7]}}, operand2};
        end else if (dec_now.taken) begin
            next_pc_d = seq_pc + {{(AW-8){operand1[7]}}, operand1};
        end else begin
            next_pc_d = seq_pc;
        end
    end

    // Interrupt pin level changes once the last two stages agree.
    always_comb begin
        irq_lvl_d = (irq_s2_q == irq_s3_q) ? irq_s2_q : irq_lvl_q;
    end

    // Sequencer next state: one instruction at a time, busy for its cycles.
    always_comb begin
        take = op_valid && (st_q == RBBD_ST_IDLE);
        st_d = st_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        dec_valid_d = 1'b0;
        dec_d = dec_q;
        case (st_q)
            RBBD_ST_IDLE: begin
                // Requests while running are ignored; the CPU waits on busy.
                if (take) begin
                    st_d = RBBD_ST_RUN;
                    cnt_d = dec_now.cyc;
                    busy_d = 1'b1;
                    dec_valid_d = 1'b1;
                    dec_d = dec_now;
                end
            end
            RBBD_ST_RUN: begin
                if (cnt_q <= 4'h1) begin
                    st_d = RBBD_ST_IDLE;
                    cnt_d = 4'h0;
                    busy_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                st_d = RBBD_ST_IDLE;
                cnt_d = 4'h0;
                busy_d = 1'b0;
            end
        endcase
    end

    // Registers; reset is synchronous and loads constants only.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            irq_s3_q <= 1'b0;
            irq_lvl_q <= 1'b0;
            st_q <= RBBD_ST_IDLE;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            dec_valid_q <= 1'b0;
            dec_q <= '0;
            next_pc_q <= '0;
            bit_addr_q <= '0;
        end else begin
            irq_s1_q <= irq_pin;
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            irq_lvl_q <= irq_lvl_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            dec_valid_q <= dec_valid_d;
            dec_q <= dec_d;
            if (take) begin
                next_pc_q <= next_pc_d;
                bit_addr_q <= bit_addr_d;
            end
        end
    end

    // Checks on the decode results and the timing.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ror_dir_time_a: assert property (
        take && opcode == {RBBD_MODE_DIR, RBBD_OPL_ROR} |=> dec_valid_q &&
        dec_q.cyc == 4'h6 && dec_q.len == 2'h2 && dec_q.wb)
        else $error("rotate right direct timing wrong");
    rol_ix1_time_a: assert property (
        take && opcode == {RBBD_MODE_IX1, RBBD_OPL_ROL} |=>
        dec_q.cyc == 4'h7 && dec_q.len == 2'h2)
        else $error("rotate left offset timing wrong");
    tst_no_wb_a: assert property (
        dec_valid_q && dec_q.cls == RBBD_CLS_TST |-> !dec_q.wb)
        else $error("test wrote back");
    tst_acc_time_a: assert property (
        take && opcode == {RBBD_MODE_ACC, RBBD_OPL_TST} |=>
        dec_q.cyc == 4'h4 && dec_q.len == 2'h1)
        else $error("test accumulator timing wrong");
    br_busy_len_a: assert property (
        take && is_branch(opcode) |=> busy_q [*4] ##1 !busy_q)
        else $error("branch not four cycles");
    bcs_cond_a: assert property (
        take && opcode == RBBD_OP_BCS |=> dec_q.taken == $past(flags.c))
        else $error("carry set branch wrong");
    bil_cond_a: assert property (
        take && opcode == RBBD_OP_BIL |=> dec_q.taken == !$past(irq_lvl_q))
        else $error("interrupt low branch wrong");
    btb_time_a: assert property (
        take && opcode[7:4] == RBBD_HI_BTB |=> dec_q.len == 2'h3 &&
        busy_q [*8] ##1 busy_q ##1 busy_q ##1 !busy_q)
        else $error("bit branch timing wrong");
    bsc_time_a: assert property (
        take && opcode[7:4] == RBBD_HI_BSC |=> dec_q.cyc == 4'h7 &&
        dec_q.cls == (opcode[0] ? RBBD_CLS_CLEAR_MEMORY_BIT : RBBD_CLS_SET_MEMORY_BIT))
        else $error("bit set clear decode wrong");
    zp_addr_a: assert property (
        dec_valid_q |-> bit_addr_q[AW-1:8] == '0)
        else $error("bit address above page zero");
    target_a: assert property (
        dec_valid_q && dec_q.cls == RBBD_CLS_BRANCH && !dec_q.taken |->
        next_pc_q == $past(instr_addr) + AW'(2))
        else $error("untaken branch not sequential");

    taken_br_c: cover property (dec_valid_q && dec_q.taken &&
        dec_q.cls == RBBD_CLS_BRANCH);
    btb_c: cover property (dec_valid_q && dec_q.cls == RBBD_CLS_BTB);
    rmw_c: cover property (dec_valid_q && dec_q.cls == RBBD_CLS_ROR);
    unk_c: cover property (dec_valid_q && !dec_q.known);
endmodule : rbbd_decoder

// ==== rtl/rbbd_pkg.sv ====
// Constants and carrier types for the instruction group decoder.
package rbbd_pkg;
    // Address width of the program counter.
    localparam int RBBD_AW = 16;
    // High nibble of a read/modify/write opcode selects the addressing form.
    localparam logic [3:0] RBBD_MODE_ACC = 4'h4;
    localparam logic [3:0] RBBD_MODE_IDX = 4'h5;
    localparam logic [3:0] RBBD_MODE_DIR = 4'h3;
    localparam logic [3:0] RBBD_MODE_IX0 = 4'h7;
    localparam logic [3:0] RBBD_MODE_IX1 = 4'h6;
    // Low nibble of a read/modify/write opcode selects the operation.
    localparam logic [3:0] RBBD_OPL_ROR = 4'h6;
    localparam logic [3:0] RBBD_OPL_ROL = 4'h9;
    localparam logic [3:0] RBBD_OPL_TST = 4'hD;
    // Relative branch opcodes handled here.
    localparam logic [7:0] RBBD_OP_BHI = 8'h22;
    localparam logic [7:0] RBBD_OP_BLS = 8'h23;
    localparam logic [7:0] RBBD_OP_BCC = 8'h24;
    localparam logic [7:0] RBBD_OP_BCS = 8'h25;
    localparam logic [7:0] RBBD_OP_BRANCH_IF_HALF_CARRY_CLEAR = 8'h28;
    localparam logic [7:0] RBBD_OP_BRANCH_IF_HALF_CARRY_SET = 8'h29;
    localparam logic [7:0] RBBD_OP_BMC = 8'h2C;
    localparam logic [7:0] RBBD_OP_BMS = 8'h2D;
    localparam logic [7:0] RBBD_OP_BIL = 8'h2E;
    localparam logic [7:0] RBBD_OP_BIH = 8'h2F;
    // High nibble of bit test-and-branch and of bit set/clear opcodes.
    localparam logic [3:0] RBBD_HI_BTB = 4'h0;
    localparam logic [3:0] RBBD_HI_BSC = 4'h1;
    // Instruction lengths in bytes.
    localparam logic [1:0] RBBD_LEN1 = 2'h1;
    localparam logic [1:0] RBBD_LEN2 = 2'h2;
    localparam logic [1:0] RBBD_LEN3 = 2'h3;
    // Execution cycle counts.
    localparam logic [3:0] RBBD_CYC_REG = 4'h4;
    localparam logic [3:0] RBBD_CYC_MEM = 4'h6;
    localparam logic [3:0] RBBD_CYC_IX1 = 4'h7;
    localparam logic [3:0] RBBD_CYC_BR = 4'h4;
    localparam logic [3:0] RBBD_CYC_BTB = 4'hA;
    localparam logic [3:0] RBBD_CYC_BSC = 4'h7;
    localparam logic [3:0] RBBD_CYC_UNK = 4'h1;
    // Operation class, one-hot.
    typedef enum logic [7:0] {
        RBBD_CLS_NONE = 8'h01,
        RBBD_CLS_ROR = 8'h02,
        RBBD_CLS_ROL = 8'h04,
        RBBD_CLS_TST = 8'h08,
        RBBD_CLS_BRANCH = 8'h10,
        RBBD_CLS_BTB = 8'h20,
        RBBD_CLS_SET_MEMORY_BIT = 8'h40,
        RBBD_CLS_CLEAR_MEMORY_BIT = 8'h80
    } rbbd_cls_e;
    // Sequencer state, one-hot.
    typedef enum logic [1:0] {
        RBBD_ST_IDLE = 2'h1,
        RBBD_ST_RUN = 2'h2
    } rbbd_st_e;
    // Condition-code flags from the datapath.
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } rbbd_flg_s;
    // Decoded instruction description.
    typedef struct packed {
        rbbd_cls_e cls;
        logic known;
        logic [3:0] mode;
        logic [1:0] len;
        logic [3:0] cyc;
        logic wb;
        logic taken;
        logic [2:0] bitn;
    } rbbd_dec_s;
endpackage : rbbd_pkg
